// >>> rtl/xcct_chain.sv
// Purpose: One XOR chain, a ripple of two-input XOR gates across its pins
// Assumes: WIDTH is below the gate limit
// Notes: Purely combinational so the tester needs no clock to read it
`timescale 1ns/1ps
`default_nettype none
module xcct_chain
  import xcct_pkg::*;
#(
  parameter int WIDTH = 35
) (
  input wire logic [WIDTH-1:0] pin_in,
  output logic result
);

  logic [WIDTH:0] stage;

  // Seed of the first gate is tied high, so all-low inputs give a one
  assign stage[0] = 1'b1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_gate
      assign stage[i+1] = stage[i] ^ pin_in[i];
    end
  endgenerate

  assign result = stage[WIDTH];

endmodule
`default_nettype wire

// >>> rtl/xcct_entry.sv
// Purpose: Coded entry sequence that opens test mode for the last two chains
// Assumes: Strap, tv clock and tv data are synchronous to clk
// Notes: Any wrong or out of order code drops back to normal until the next reset
`timescale 1ns/1ps
`default_nettype none
module xcct_entry
  import xcct_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic mem_addr_bit2_strap,
  input wire logic tv_port_clock,
  input wire logic [XCCT_CODE_BITS-1:0] tv_port_data_hi,
  output logic test_active
);

  typedef struct packed {
    logic in_reset;
    logic clock_q;
    logic held;
    logic [XCCT_CODE_BITS-1:0] code;
    xcct_entry_state_t state;
    logic active;
  } xcct_entry_reg_t;

  localparam xcct_entry_reg_t XCCT_ENTRY_RESET = '{
    in_reset: 1'b1,
    clock_q: 1'b0,
    held: 1'b0,
    code: '0,
    state: XCCT_ST_NORMAL,
    active: 1'b0
  };

  xcct_entry_reg_t cur;
  xcct_entry_reg_t next_cur;
  logic rise;
  logic fall;
  logic good_first;
  logic good_second;

  always_comb begin
    next_cur = cur;
    next_cur.in_reset = 1'b0;
    next_cur.clock_q = tv_port_clock;
    rise = !cur.clock_q && tv_port_clock;
    fall = cur.clock_q && !tv_port_clock;
    // The code must stay put across the whole high phase of the strobe
    good_first = cur.held && (cur.code == XCCT_CODE_FIRST) && (tv_port_data_hi == cur.code);
    good_second = cur.held && (cur.code == XCCT_CODE_SECOND) && (tv_port_data_hi == cur.code);
    if (rise) begin
      next_cur.code = tv_port_data_hi;
      next_cur.held = 1'b1;
    end else if (cur.clock_q && (tv_port_data_hi != cur.code)) begin
      next_cur.held = 1'b0;
    end
    if (cur.in_reset) begin
      // Strap is caught on the first edge after reset lets go
      if (mem_addr_bit2_strap == XCCT_STRAP_ACTIVE) begin
        next_cur.state = XCCT_ST_WAIT_FIRST;
      end else begin
        next_cur.state = XCCT_ST_NORMAL;
      end
    end else if (fall) begin
      case (cur.state)
        XCCT_ST_WAIT_FIRST: begin
          next_cur.state = good_first ? XCCT_ST_WAIT_SECOND : XCCT_ST_NORMAL;
        end
        XCCT_ST_WAIT_SECOND: begin
          next_cur.state = good_second ? XCCT_ST_TEST : XCCT_ST_NORMAL;
        end
        XCCT_ST_TEST: begin
          next_cur.state = XCCT_ST_TEST;
        end
        XCCT_ST_NORMAL: begin
          next_cur.state = XCCT_ST_NORMAL;
        end
        default: begin
          next_cur.state = XCCT_ST_NORMAL;
        end
      endcase
    end
    next_cur.active = (next_cur.state == XCCT_ST_TEST);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cur <= XCCT_ENTRY_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign test_active = cur.active;

endmodule
`default_nettype wire

// >>> rtl/xcct_pkg.sv
// Purpose: Shared constants and types for the XOR chain connectivity test block
// Assumes: Chain pins and result pins are ordinary device pins seen through IO buffers
// Notes: Chain k of the outside world is index k-1 here
package xcct_pkg;

  localparam int XCCT_NUM_CHAINS = 8;
  // Every chain must stay below this gate count
  localparam int XCCT_GATE_LIMIT = 65;
  localparam int XCCT_WIDTHS [XCCT_NUM_CHAINS] = '{35, 33, 38, 36, 56, 60, 33, 31};
  // Chains 0..5 follow the row strap, chains 6..7 the coded entry
  localparam int XCCT_LAST_STRAP_CHAIN = 5;

  localparam logic XCCT_STRAP_ACTIVE = 1'b0;
  localparam int XCCT_CODE_BITS = 6;
  localparam logic [XCCT_CODE_BITS-1:0] XCCT_CODE_FIRST = 6'h2d;
  localparam logic [XCCT_CODE_BITS-1:0] XCCT_CODE_SECOND = 6'h23;

  // Output enables are active low: one means the pin is not driven
  localparam logic XCCT_OE_OFF = 1'b1;

  function automatic int xcct_offset(input int idx);
    int sum;
    sum = 0;
    for (int k = 0; k < idx; k++) begin
      sum = sum + XCCT_WIDTHS[k];
    end
    return sum;
  endfunction

  localparam int XCCT_TOTAL_PINS = xcct_offset(XCCT_NUM_CHAINS);

  typedef enum logic [3:0] {
    XCCT_ST_NORMAL = 4'b0001,
    XCCT_ST_WAIT_FIRST = 4'b0010,
    XCCT_ST_WAIT_SECOND = 4'b0100,
    XCCT_ST_TEST = 4'b1000
  } xcct_entry_state_t;

endpackage

// >>> rtl/xcct_top.sv
// Purpose: XOR chain board connectivity test logic wrapped around eight pin groups
// Assumes: reset is the device reset pin seen high while asserted, all pins synchronous to clk
// Notes: Result pins are muxed combinationally so chains read with no clock running
//
// What this block does
// - Each chain is a ripple of XOR gates
// - First gate seeded with a constant one
// - Last gate drives the chain's result pin
// - Eight chains, each under sixty-five gates
// - Even count of high inputs gives one
// - Chain pins stop driving while their own chain is in test mode
// - Row strap low at reset enables chains 1-6
// - Chain evaluation needs no clock
// - Address strap low at reset arms chains 7-8
// - First tv code 101101 taken on strobe
// - Second tv code 100011 completes entry
// - Coded entry opens only chains 7 and 8
// - Chain 1: 35 inputs onto address bit 5
// - Chain 2: 33 inputs onto bit 2 strap
// - Chain 3: 38 inputs onto address bit 0
// - Chain 4: 36 inputs onto address bit 9
`timescale 1ns/1ps
`default_nettype none
module xcct_top
  import xcct_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic row_addr_strobe_strap,
  input wire logic mem_addr_bit2_strap_in,
  input wire logic tv_port_clock,
  input wire logic [XCCT_CODE_BITS-1:0] tv_port_data_hi,
  input wire logic [XCCT_WIDTHS[0]-1:0] chain1_pin_in,
  input wire logic [XCCT_WIDTHS[1]-1:0] chain2_pin_in,
  input wire logic [XCCT_WIDTHS[2]-1:0] chain3_pin_in,
  input wire logic [XCCT_WIDTHS[3]-1:0] chain4_pin_in,
  input wire logic [XCCT_WIDTHS[4]-1:0] chain5_pin_in,
  input wire logic [XCCT_WIDTHS[5]-1:0] chain6_pin_in,
  input wire logic [XCCT_WIDTHS[6]-1:0] chain7_pin_in,
  input wire logic [XCCT_WIDTHS[7]-1:0] chain8_pin_in,
  input wire logic [XCCT_WIDTHS[0]-1:0] chain1_func_oe_n,
  input wire logic [XCCT_WIDTHS[1]-1:0] chain2_func_oe_n,
  input wire logic [XCCT_WIDTHS[2]-1:0] chain3_func_oe_n,
  input wire logic [XCCT_WIDTHS[3]-1:0] chain4_func_oe_n,
  input wire logic [XCCT_WIDTHS[4]-1:0] chain5_func_oe_n,
  input wire logic [XCCT_WIDTHS[5]-1:0] chain6_func_oe_n,
  input wire logic [XCCT_WIDTHS[6]-1:0] chain7_func_oe_n,
  input wire logic [XCCT_WIDTHS[7]-1:0] chain8_func_oe_n,
  input wire logic func_mem_addr_bit5,
  input wire logic func_mem_addr_bit2,
  input wire logic func_mem_addr_bit2_oe_n,
  input wire logic func_mem_addr_bit0,
  input wire logic func_mem_addr_bit9,
  input wire logic func_mem_data_bit31,
  input wire logic func_mem_addr_bit11,
  input wire logic func_mem_addr_bit8,
  input wire logic func_mem_addr_bit4,
  output logic [XCCT_WIDTHS[0]-1:0] chain1_pin_oe_n,
  output logic [XCCT_WIDTHS[1]-1:0] chain2_pin_oe_n,
  output logic [XCCT_WIDTHS[2]-1:0] chain3_pin_oe_n,
  output logic [XCCT_WIDTHS[3]-1:0] chain4_pin_oe_n,
  output logic [XCCT_WIDTHS[4]-1:0] chain5_pin_oe_n,
  output logic [XCCT_WIDTHS[5]-1:0] chain6_pin_oe_n,
  output logic [XCCT_WIDTHS[6]-1:0] chain7_pin_oe_n,
  output logic [XCCT_WIDTHS[7]-1:0] chain8_pin_oe_n,
  output logic mem_addr_bit5_out,
  output logic mem_addr_bit2_strap_out,
  output logic mem_addr_bit2_strap_oe_n,
  output logic mem_addr_bit0_out,
  output logic mem_addr_bit9_out,
  output logic mem_data_bit31_out,
  output logic mem_addr_bit11_out,
  output logic mem_addr_bit8_out,
  output logic mem_addr_bit4_out,
  output logic test_low_chains_active,
  output logic test_high_chains_active
);

  typedef struct packed {
    logic in_reset;
    logic low_test;
    logic bit2_oe_n;
    logic [XCCT_TOTAL_PINS-1:0] pin_oe_n;
  } xcct_top_reg_t;

  localparam xcct_top_reg_t XCCT_TOP_RESET = '{
    in_reset: 1'b1,
    low_test: 1'b0,
    bit2_oe_n: XCCT_OE_OFF,
    pin_oe_n: {XCCT_TOTAL_PINS{XCCT_OE_OFF}}
  };

  xcct_top_reg_t cur;
  xcct_top_reg_t next_cur;
  logic high_test;
  logic [XCCT_TOTAL_PINS-1:0] pins_all;
  logic [XCCT_TOTAL_PINS-1:0] func_oe_all;
  logic [XCCT_TOTAL_PINS-1:0] oe_force;
  logic [XCCT_NUM_CHAINS-1:0] chain_test;
  logic [XCCT_NUM_CHAINS-1:0] chain_result;

  assign pins_all = {chain8_pin_in, chain7_pin_in, chain6_pin_in, chain5_pin_in,
                     chain4_pin_in, chain3_pin_in, chain2_pin_in, chain1_pin_in};
  assign func_oe_all = {chain8_func_oe_n, chain7_func_oe_n, chain6_func_oe_n,
                        chain5_func_oe_n, chain4_func_oe_n, chain3_func_oe_n,
                        chain2_func_oe_n, chain1_func_oe_n};

  xcct_entry u_entry (
    .clk(clk),
    .reset(reset),
    .mem_addr_bit2_strap(mem_addr_bit2_strap_in),
    .tv_port_clock(tv_port_clock),
    .tv_port_data_hi(tv_port_data_hi),
    .test_active(high_test)
  );

  genvar c;
  generate
    for (c = 0; c < XCCT_NUM_CHAINS; c++) begin : g_chain
      localparam int OFF = xcct_offset(c);
      localparam int W = XCCT_WIDTHS[c];
      if (W >= XCCT_GATE_LIMIT) begin : g_too_long
        $error("chain too long");
      end
      if (c <= XCCT_LAST_STRAP_CHAIN) begin : g_low
        assign chain_test[c] = cur.low_test;
      end else begin : g_high
        assign chain_test[c] = high_test;
      end
      assign oe_force[OFF +: W] = {W{chain_test[c]}};
      xcct_chain #(
        .WIDTH(W)
      ) u_chain (
        .pin_in(pins_all[OFF +: W]),
        .result(chain_result[c])
      );
    end
  endgenerate

  always_comb begin
    next_cur = cur;
    next_cur.in_reset = 1'b0;
    // Strap is caught on the first edge after reset lets go, then held
    if (cur.in_reset) begin
      next_cur.low_test = (row_addr_strobe_strap == XCCT_STRAP_ACTIVE);
    end
    // Chain pins are pure inputs while their chain is under test
    next_cur.pin_oe_n = func_oe_all | oe_force;
    // Strap pin doubles as chain 2 result, so it is forced to drive in test and follows its functional enable otherwise
    next_cur.bit2_oe_n = next_cur.low_test ? 1'b0 : func_mem_addr_bit2_oe_n;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cur <= XCCT_TOP_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign chain1_pin_oe_n = cur.pin_oe_n[xcct_offset(0) +: XCCT_WIDTHS[0]];
  assign chain2_pin_oe_n = cur.pin_oe_n[xcct_offset(1) +: XCCT_WIDTHS[1]];
  assign chain3_pin_oe_n = cur.pin_oe_n[xcct_offset(2) +: XCCT_WIDTHS[2]];
  assign chain4_pin_oe_n = cur.pin_oe_n[xcct_offset(3) +: XCCT_WIDTHS[3]];
  assign chain5_pin_oe_n = cur.pin_oe_n[xcct_offset(4) +: XCCT_WIDTHS[4]];
  assign chain6_pin_oe_n = cur.pin_oe_n[xcct_offset(5) +: XCCT_WIDTHS[5]];
  assign chain7_pin_oe_n = cur.pin_oe_n[xcct_offset(6) +: XCCT_WIDTHS[6]];
  assign chain8_pin_oe_n = cur.pin_oe_n[xcct_offset(7) +: XCCT_WIDTHS[7]];
  assign mem_addr_bit2_strap_oe_n = cur.bit2_oe_n;

  // Results bypass any flop: the tester may read them with the clock stopped
  assign mem_addr_bit5_out = chain_test[0] ? chain_result[0] : func_mem_addr_bit5;
  assign mem_addr_bit2_strap_out = chain_test[1] ? chain_result[1] : func_mem_addr_bit2;
  assign mem_addr_bit0_out = chain_test[2] ? chain_result[2] : func_mem_addr_bit0;
  assign mem_addr_bit9_out = chain_test[3] ? chain_result[3] : func_mem_addr_bit9;
  assign mem_data_bit31_out = chain_test[4] ? chain_result[4] : func_mem_data_bit31;
  assign mem_addr_bit11_out = chain_test[5] ? chain_result[5] : func_mem_addr_bit11;
  assign mem_addr_bit8_out = chain_test[6] ? chain_result[6] : func_mem_addr_bit8;
  assign mem_addr_bit4_out = chain_test[7] ? chain_result[7] : func_mem_addr_bit4;

  assign test_low_chains_active = cur.low_test;
  assign test_high_chains_active = high_test;

endmodule
`default_nettype wire

// >>> sim/xcct_monitor.sv
// Purpose: Port-level checks for the XOR chain test block
// Assumes: Straps and tv port sampled on clk, result pins combinational
// Notes: Output enables are registered, so oe checks wait one settled cycle
`timescale 1ns/1ps
`default_nettype none
module xcct_monitor
  import xcct_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic row_addr_strobe_strap,
  input wire logic tv_port_clock,
  input wire logic [XCCT_CODE_BITS-1:0] tv_port_data_hi,
  input wire logic [XCCT_WIDTHS[0]-1:0] chain1_pin_in,
  input wire logic [XCCT_WIDTHS[1]-1:0] chain2_pin_in,
  input wire logic [XCCT_WIDTHS[6]-1:0] chain7_pin_in,
  input wire logic [XCCT_WIDTHS[2]-1:0] chain3_pin_oe_n,
  input wire logic [XCCT_WIDTHS[6]-1:0] chain7_pin_oe_n,
  input wire logic func_mem_addr_bit5,
  input wire logic func_mem_addr_bit8,
  input wire logic mem_addr_bit5_out,
  input wire logic mem_addr_bit2_strap_out,
  input wire logic mem_addr_bit2_strap_oe_n,
  input wire logic mem_addr_bit8_out,
  input wire logic test_low_chains_active,
  input wire logic test_high_chains_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_release_low;
    $past(reset) && !row_addr_strobe_strap;
  endsequence
  sequence s_low_settled;
    test_low_chains_active && $past(test_low_chains_active);
  endsequence
  AST_LOW_ENTRY: assert property (s_release_low |=> test_low_chains_active)
    else $error("low chains not entered after strap release");
  AST_LOW_HOLD: assert property (test_low_chains_active |=> test_low_chains_active)
    else $error("low chain mode dropped without reset");
  AST_HIGH_CAUSE: assert property ($rose(test_high_chains_active) |->
    $past(tv_port_data_hi) == XCCT_CODE_SECOND && !$past(tv_port_clock))
    else $error("high chain mode entered without second code");
  AST_HIGH_HOLD: assert property (test_high_chains_active |=> test_high_chains_active)
    else $error("high chain mode dropped without reset");
  AST_CHAIN1: assert property (test_low_chains_active |->
    mem_addr_bit5_out == ~^chain1_pin_in)
    else $error("chain one parity wrong");
  AST_CHAIN2: assert property (s_low_settled |->
    !mem_addr_bit2_strap_oe_n && mem_addr_bit2_strap_out == ~^chain2_pin_in)
    else $error("chain two result not driven");
  AST_CHAIN7: assert property (test_high_chains_active |->
    mem_addr_bit8_out == ~^chain7_pin_in)
    else $error("chain seven parity wrong");
  AST_FUNC1: assert property (!test_low_chains_active |->
    mem_addr_bit5_out == func_mem_addr_bit5)
    else $error("result pin one not functional");
  AST_FUNC7: assert property (!test_high_chains_active |->
    mem_addr_bit8_out == func_mem_addr_bit8)
    else $error("result pin seven not functional");
  AST_OE_LOW: assert property (s_low_settled |-> &chain3_pin_oe_n)
    else $error("chain three pins still driving");
  AST_OE_HIGH: assert property (test_high_chains_active && $past(test_high_chains_active)
    |-> &chain7_pin_oe_n)
    else $error("chain seven pins still driving");
endmodule
bind xcct_top xcct_monitor mon (.*);
`default_nettype wire

// >>> sim/xcct_tb_top.sv
// Purpose: Self-checking bench for the XOR chain test block
// Assumes: Chains numbered from zero in tables, result pins collected in order
// Notes: The chain 1 walk checks one ns after the edge to show no clock is needed
`timescale 1ns/1ps
`default_nettype none
module xcct_tb_top;
  import xcct_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic row_addr_strobe_strap = 1'b1;
  logic mem_addr_bit2_strap_in = 1'b1;
  logic tv_port_clock;
  logic [XCCT_CODE_BITS-1:0] tv_port_data_hi;
  logic [XCCT_WIDTHS[0]-1:0] chain1_pin_in = '0, chain1_func_oe_n = '1, chain1_pin_oe_n;
  logic [XCCT_WIDTHS[1]-1:0] chain2_pin_in = '0, chain2_func_oe_n = '1, chain2_pin_oe_n;
  logic [XCCT_WIDTHS[2]-1:0] chain3_pin_in = '0, chain3_func_oe_n = '1, chain3_pin_oe_n;
  logic [XCCT_WIDTHS[3]-1:0] chain4_pin_in = '0, chain4_func_oe_n = '1, chain4_pin_oe_n;
  logic [XCCT_WIDTHS[4]-1:0] chain5_pin_in = '0, chain5_func_oe_n = '1, chain5_pin_oe_n;
  logic [XCCT_WIDTHS[5]-1:0] chain6_pin_in = '0, chain6_func_oe_n = '1, chain6_pin_oe_n;
  logic [XCCT_WIDTHS[6]-1:0] chain7_pin_in = '0, chain7_func_oe_n = '1, chain7_pin_oe_n;
  logic [XCCT_WIDTHS[7]-1:0] chain8_pin_in = '0, chain8_func_oe_n = '1, chain8_pin_oe_n;
  logic func_mem_addr_bit5 = 1'b0, func_mem_addr_bit2 = 1'b0, func_mem_addr_bit2_oe_n = 1'b0;
  logic func_mem_addr_bit0 = 1'b0, func_mem_addr_bit9 = 1'b0, func_mem_data_bit31 = 1'b0;
  logic func_mem_addr_bit11 = 1'b0, func_mem_addr_bit8 = 1'b0, func_mem_addr_bit4 = 1'b0;
  logic mem_addr_bit5_out, mem_addr_bit2_strap_out, mem_addr_bit2_strap_oe_n;
  logic mem_addr_bit0_out, mem_addr_bit9_out, mem_data_bit31_out, mem_addr_bit11_out;
  logic mem_addr_bit8_out, mem_addr_bit4_out, test_low_chains_active, test_high_chains_active;
  // Strobe positions inside the chains are a bench choice; the n side is driven inverted
  localparam logic [XCCT_WIDTHS[3]-1:0] HUB_N_MASK = 36'h4;
  localparam logic [XCCT_WIDTHS[7]-1:0] AGP_N_MASK = 31'h7;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  wire logic [7:0] res_out = {mem_addr_bit4_out, mem_addr_bit8_out, mem_addr_bit11_out,
    mem_data_bit31_out, mem_addr_bit9_out, mem_addr_bit0_out, mem_addr_bit2_strap_out,
    mem_addr_bit5_out};
  wire logic [7:0] oe_all = {&chain8_pin_oe_n, &chain7_pin_oe_n, &chain6_pin_oe_n,
    &chain5_pin_oe_n, &chain4_pin_oe_n, &chain3_pin_oe_n, &chain2_pin_oe_n, &chain1_pin_oe_n};

  xcct_top dut (.*);
  xcct_tester tester (.clk(clk), .tv_port_clock(tv_port_clock),
    .tv_port_data_hi(tv_port_data_hi));

  always #5 clk = ~clk;

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Bounded run: a stuck handshake ends here rather than hanging
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic do_reset(input logic row, input logic b2);
    @(posedge clk);
    reset <= 1'b1;
    row_addr_strobe_strap <= row;
    mem_addr_bit2_strap_in <= b2;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Functional enables follow the inverse of the pin level so normal mode shows them
  task automatic set_all(input logic v);
    @(posedge clk);
    chain1_pin_in <= {XCCT_WIDTHS[0]{v}};
    chain2_pin_in <= {XCCT_WIDTHS[1]{v}};
    chain3_pin_in <= {XCCT_WIDTHS[2]{v}};
    chain4_pin_in <= {XCCT_WIDTHS[3]{v}} ^ HUB_N_MASK;
    chain5_pin_in <= {XCCT_WIDTHS[4]{v}};
    chain6_pin_in <= {XCCT_WIDTHS[5]{v}};
    chain7_pin_in <= {XCCT_WIDTHS[6]{v}};
    chain8_pin_in <= {XCCT_WIDTHS[7]{v}} ^ AGP_N_MASK;
    chain1_func_oe_n <= {XCCT_WIDTHS[0]{!v}};
    chain2_func_oe_n <= {XCCT_WIDTHS[1]{!v}};
    chain3_func_oe_n <= {XCCT_WIDTHS[2]{!v}};
    chain4_func_oe_n <= {XCCT_WIDTHS[3]{!v}};
    chain5_func_oe_n <= {XCCT_WIDTHS[4]{!v}};
    chain6_func_oe_n <= {XCCT_WIDTHS[5]{!v}};
    chain7_func_oe_n <= {XCCT_WIDTHS[6]{!v}};
    chain8_func_oe_n <= {XCCT_WIDTHS[7]{!v}};
    {func_mem_addr_bit5, func_mem_addr_bit2, func_mem_addr_bit2_oe_n, func_mem_addr_bit0,
      func_mem_addr_bit9, func_mem_data_bit31, func_mem_addr_bit11, func_mem_addr_bit8,
      func_mem_addr_bit4} <= {9{v}};
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic check_all(input logic v, input logic lo, input logic hi);
    logic on;
    int ones;
    for (int k = 0; k < XCCT_NUM_CHAINS; k++) begin
      on = (k <= XCCT_LAST_STRAP_CHAIN) ? lo : hi;
      // Inverted strobe pins in chains 4 and 8 shift the count of high inputs
      ones = (k == 3) ? $countones(HUB_N_MASK) : (k == 7) ? $countones(AGP_N_MASK) : 0;
      if (v) begin
        ones = XCCT_WIDTHS[k] - ones;
      end
      chk(res_out[k], on ? !ones[0] : v);
      chk(oe_all[k], on || !v);
    end
  endtask

  task automatic sc_low();
    do_reset(1'b0, 1'b1);
    row_addr_strobe_strap <= 1'b1;
    @(negedge clk);
    chk(test_low_chains_active, 1'b1);
    chk(test_high_chains_active, 1'b0);
    set_all(1'b0);
    check_all(1'b0, 1'b1, 1'b0);
    chk(mem_addr_bit2_strap_oe_n, 1'b0);
    for (int i = 0; i < XCCT_WIDTHS[0]; i++) begin
      @(posedge clk);
      chain1_pin_in[i] <= 1'b1;
      #1 chk(mem_addr_bit5_out, i[0]);
    end
    set_all(1'b1);
    check_all(1'b1, 1'b1, 1'b0);
  endtask

  task automatic sc_high();
    do_reset(1'b1, 1'b0);
    tester.send_code(XCCT_CODE_FIRST);
    tester.send_code(XCCT_CODE_SECOND);
    @(negedge clk);
    chk(test_high_chains_active, 1'b1);
    chk(test_low_chains_active, 1'b0);
    set_all(1'b1);
    check_all(1'b1, 1'b0, 1'b1);
    set_all(1'b0);
    check_all(1'b0, 1'b0, 1'b1);
  endtask

  // Codes in swapped order must leave the block in normal operation
  task automatic sc_bad();
    do_reset(1'b1, 1'b0);
    tester.send_code(XCCT_CODE_SECOND);
    tester.send_code(XCCT_CODE_FIRST);
    @(negedge clk);
    chk(test_high_chains_active, 1'b0);
    set_all(1'b1);
    check_all(1'b1, 1'b0, 1'b0);
    chk(mem_addr_bit2_strap_oe_n, 1'b1);
  endtask

  task automatic sc_normal();
    do_reset(1'b1, 1'b1);
    @(negedge clk);
    chk(test_low_chains_active, 1'b0);
    set_all(1'b0);
    check_all(1'b0, 1'b0, 1'b0);
  endtask

  initial begin
    sc_low();
    sc_high();
    sc_bad();
    sc_normal();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> sim/xcct_tester.sv
// Purpose: Board tester model sending coded entry strobes
// Assumes: Driven on clk rising edges
// Notes: Each strobe phase spans two cycles so a sampled edge is never missed
`timescale 1ns/1ps
`default_nettype none
module xcct_tester
  import xcct_pkg::*;
(
  input wire logic clk,
  output logic tv_port_clock,
  output logic [XCCT_CODE_BITS-1:0] tv_port_data_hi
);
  initial begin
    tv_port_clock = 1'b0;
    tv_port_data_hi = 6'h00;
  end
  // Data is held until the next code, never changed while the strobe is high
  task automatic send_code(input logic [XCCT_CODE_BITS-1:0] code);
    @(posedge clk);
    tv_port_clock <= 1'b0;
    tv_port_data_hi <= code;
    repeat (2) @(posedge clk);
    tv_port_clock <= 1'b1;
    repeat (2) @(posedge clk);
    tv_port_clock <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire
